// *** hdl/sktsm_edge_detect.sv ***
`timescale 1ns/1ps
// change detector for one socket line, with edge-mode select
module sktsm_edge_detect (
   // clock and reset
   input  wire logic mclk,
   input  wire logic sys_rst,
   // line
   input  wire logic lineIn,
   input  wire logic risingOnly,
   // result
   output logic      changePulse
);
   logic lastR;
   wire  riseW = lineIn & ~lastR;
   wire  anyW  = lineIn ^ lastR;

   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) lastR <= 1'b0;
      else lastR <= lineIn;
   end

   assign changePulse = risingOnly ? riseW : anyW;
endmodule // sktsm_edge_detect

// *** hdl/sktsm_pkg.sv ***
package sktsm_pkg;
   // register offsets
   localparam logic [7:0] OFF_EVENT   = 8'h00;
   localparam logic [7:0] OFF_MASK    = 8'h04;
   localparam logic [7:0] OFF_PRESENT = 8'h08;
   localparam logic [7:0] OFF_FORCE   = 8'h0C;
   // mask and event field positions
   localparam int POS_PWR  = 3;
   localparam int POS_CD2  = 2;
   localparam int POS_CD1  = 1;
   localparam int POS_CSTS = 0;
   localparam int MASK_W   = 4;
   // present-state field positions, plus the force-only reinterrogate bit
   localparam int POS_SOCK_Y    = 31;
   localparam int POS_SOCK_X    = 30;
   localparam int POS_SOCK_LOW  = 29;
   localparam int POS_SOCK_HIGH = 28;
   localparam int POS_CARD_HI   = 13;
   localparam int POS_CARD_LO   = 10;
   localparam int POS_BADREQ    = 9;
   localparam int POS_DLOSS     = 8;
   localparam int POS_NOCARD    = 7;
   localparam int POS_INTPIN    = 6;
   localparam int POS_CBCARD    = 5;
   localparam int POS_16CARD    = 4;
   localparam int POS_REINT     = 14;
   // reset values and the card-detect enable code
   localparam logic [3:0] MASK_RST   = 4'h0;
   localparam logic [3:0] SOCKV_RST  = 4'h3;
   localparam logic [1:0] CARD_DETECT_IRQ_ENABLE_ON  = 2'h3;
endpackage

// *** hdl/sktsm_socket_regs.sv ***
`timescale 1ns/1ps
//////////////////////////////////////////////////////////////////////////////
module sktsm_socket_regs (
   // clock and reset
   input  wire logic        mclk,
   input  wire logic        sys_rst,
   // register port
   input  wire logic [7:0]  regAddr,
   input  wire logic        regWrite,
   input  wire logic        regRead,
   input  wire logic [31:0] regWdata,
   output logic [31:0]      regRdata,
   // socket pins
   input  wire logic        cardDetectOnePin,
   input  wire logic        cardDetectTwoPin,
   input  wire logic        cardStatusPin,
   input  wire logic        cardIntPin,
   // interrogation and power side
   input  wire logic        socketPowered,
   input  wire logic        identifying,
   input  wire logic        insertDone,
   input  wire logic        insertValid,
   input  wire logic [3:0]  insertCardVolt,
   input  wire logic        insertCardBus,
   input  wire logic        insert16Bit,
   input  wire logic        invalidSupplyReq,
   input  wire logic        dataLossSet,
   input  wire logic        dataLossClear,
   // outputs
   output logic             cardStatusChangeIrq,
   output logic             reinterrogateReq
);
   //////////////////////////////////////////////////////////////////////////
   logic [3:0] irqEnable_r;
   logic [3:0] event_r;
   logic [3:0] sockVolt_r;
   logic [3:0] cardVolt_r;
   logic       cardBus_r;
   logic       card16_r;
   logic       badReq_r;
   logic       dataLoss_r;
   logic       notCard_r;
   logic       cdOne_r;
   logic       cdTwo_r;
   logic       pwr_r;
   logic       csts_r;
   logic       intPin_r;
   logic [31:0] present;

   // register offset match, shared by the write strobes and the read mux
   function automatic logic addrHit(input logic [7:0] addr, input logic [7:0] offset);
      return addr == offset;
   endfunction

   wire wrMask  = regWrite & addrHit(regAddr, sktsm_pkg::OFF_MASK);
   wire wrEvent = regWrite & addrHit(regAddr, sktsm_pkg::OFF_EVENT);
   wire wrForce = regWrite & addrHit(regAddr, sktsm_pkg::OFF_FORCE);

   //////////////////////////////////////////////////////////////////////////
   // mask register, only four bits stored
   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) irqEnable_r <= sktsm_pkg::MASK_RST;
      else if (wrMask) irqEnable_r <= regWdata[3:0];
   end

   //////////////////////////////////////////////////////////////////////////
   // live state bits
   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         cdOne_r  <= 1'b1;
         cdTwo_r  <= 1'b1;
         pwr_r    <= 1'b0;
         csts_r   <= 1'b0;
         intPin_r <= 1'b0;
      end else begin
         if (!identifying) begin
            cdOne_r <= cardDetectOnePin;
            cdTwo_r <= cardDetectTwoPin;
         end
         pwr_r    <= socketPowered;
         csts_r   <= cardStatusPin;
         intPin_r <= cardIntPin;
      end
   end

   //////////////////////////////////////////////////////////////////////////
   // event detection
   logic cstsChange;
   sktsm_edge_detect uCsts (
      .mclk        (mclk),
      .sys_rst     (sys_rst),
      .lineIn      (cardStatusPin),
      .risingOnly  (cardBus_r),
      .changePulse (cstsChange)
   );

   wire [3:0] hwSet = {socketPowered ^ pwr_r,
                       (!identifying) & (cardDetectTwoPin ^ cdTwo_r),
                       (!identifying) & (cardDetectOnePin ^ cdOne_r),
                       cstsChange};
   wire [3:0] forceSet = wrForce ? regWdata[3:0] : 4'h0;
   wire [3:0] swClr    = wrEvent ? regWdata[3:0] : 4'h0;
   wire [3:0] event_nxt = (event_r & ~swClr) | hwSet | forceSet;

   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) event_r <= 4'h0;
      else event_r <= event_nxt;
   end

   //////////////////////////////////////////////////////////////////////////
   // interrupt: card-detect enable counts only when field is 11
   wire cdEn = (irqEnable_r[2:1] == sktsm_pkg::CARD_DETECT_IRQ_ENABLE_ON);
   wire irq_nxt = (event_r[3] & irqEnable_r[3]) |
                  ((event_r[2] | event_r[1]) & cdEn) |
                  (event_r[0] & irqEnable_r[0]);

   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) cardStatusChangeIrq <= 1'b0;
      else cardStatusChangeIrq <= irq_nxt;
   end

   //////////////////////////////////////////////////////////////////////////
   // insertion-latched and forced state
   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         sockVolt_r <= sktsm_pkg::SOCKV_RST;
         cardVolt_r <= 4'h0;
         cardBus_r  <= 1'b0;
         card16_r   <= 1'b0;
         notCard_r  <= 1'b0;
      end else if (wrForce) begin
         cardVolt_r <= regWdata[sktsm_pkg::POS_CARD_HI:sktsm_pkg::POS_CARD_LO];
         notCard_r  <= regWdata[sktsm_pkg::POS_NOCARD];
         cardBus_r  <= regWdata[sktsm_pkg::POS_CBCARD];
         card16_r   <= regWdata[sktsm_pkg::POS_16CARD];
      end else if (insertDone) begin
         cardVolt_r <= insertCardVolt;
         cardBus_r  <= insertCardBus;
         card16_r   <= insert16Bit;
         notCard_r  <= ~insertValid;
      end
   end

   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         badReq_r   <= 1'b0;
         dataLoss_r <= 1'b0;
      end else begin
         if (invalidSupplyReq) badReq_r <= 1'b1;
         else if (wrForce) badReq_r <= regWdata[sktsm_pkg::POS_BADREQ];
         if (dataLossSet) dataLoss_r <= 1'b1;
         else if (wrForce) dataLoss_r <= regWdata[sktsm_pkg::POS_DLOSS];
         else if (dataLossClear) dataLoss_r <= 1'b0;
      end
   end

   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) reinterrogateReq <= 1'b0;
      else reinterrogateReq <= wrForce & regWdata[sktsm_pkg::POS_REINT];
   end

   //////////////////////////////////////////////////////////////////////////
   // read side; present state ignores host writes at its own offset, but force writes load several of its fields
   assign present = {sockVolt_r, 14'h0000, cardVolt_r, badReq_r, dataLoss_r,
                     notCard_r, intPin_r, cardBus_r, card16_r, pwr_r,
                     cdTwo_r, cdOne_r, csts_r};

   wire [31:0] rdMux = addrHit(regAddr, sktsm_pkg::OFF_EVENT)   ? {28'h0000000, event_r} :
                       addrHit(regAddr, sktsm_pkg::OFF_MASK)    ? {28'h0000000, irqEnable_r} :
                       addrHit(regAddr, sktsm_pkg::OFF_PRESENT) ? present : 32'h00000000;

   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) regRdata <= 32'h00000000;
      else if (regRead) regRdata <= rdMux;
   end

   //////////////////////////////////////////////////////////////////////////
   property p_mask_upper;
      @(posedge mclk) disable iff (sys_rst)
      regRead && regAddr == sktsm_pkg::OFF_MASK |=> regRdata[31:4] == 28'h0000000;
   endproperty
   a_mask_upper: assert property (p_mask_upper) else $error("mask upper bits");

   property p_event_sticky;
      @(posedge mclk) disable iff (sys_rst)
      event_r[3] && !wrEvent |=> event_r[3];
   endproperty
   a_event_sticky: assert property (p_event_sticky) else $error("event lost");

   property p_pwr_event;
      @(posedge mclk) disable iff (sys_rst)
      (socketPowered != pwr_r) |=> event_r[3];
   endproperty
   a_pwr_event: assert property (p_pwr_event) else $error("power event");

   property p_irq_pwr;
      @(posedge mclk) disable iff (sys_rst)
      event_r[3] && irqEnable_r[3] |=> cardStatusChangeIrq;
   endproperty
   a_irq_pwr: assert property (p_irq_pwr) else $error("irq missing");

   property p_irq_none;
      @(posedge mclk) disable iff (sys_rst)
      irqEnable_r == 4'h0 |=> !cardStatusChangeIrq;
   endproperty
   a_irq_none: assert property (p_irq_none) else $error("irq unmasked");

   property p_cd_partial;
      @(posedge mclk) disable iff (sys_rst)
      (event_r[2] || event_r[1]) && irqEnable_r[2:1] != sktsm_pkg::CARD_DETECT_IRQ_ENABLE_ON &&
      !irqEnable_r[3] && !irqEnable_r[0] |=> !cardStatusChangeIrq;
   endproperty
   a_cd_partial: assert property (p_cd_partial) else $error("cd partial");

   property p_csts_irq;
      @(posedge mclk) disable iff (sys_rst)
      event_r[0] && irqEnable_r[0] |=> cardStatusChangeIrq;
   endproperty
   a_csts_irq: assert property (p_csts_irq) else $error("csts irq");

   property p_reserved;
      @(posedge mclk) disable iff (sys_rst)
      regRead && regAddr == sktsm_pkg::OFF_PRESENT |=> regRdata[27:14] == 14'h0000;
   endproperty
   a_reserved: assert property (p_reserved) else $error("reserved bits");

   property p_hold_ident;
      @(posedge mclk) disable iff (sys_rst)
      identifying |=> $stable(cdOne_r) && $stable(cdTwo_r);
   endproperty
   a_hold_ident: assert property (p_hold_ident) else $error("cd moved");

   property p_volt_hold;
      @(posedge mclk) disable iff (sys_rst)
      !insertDone && !wrForce |=> $stable(cardVolt_r);
   endproperty
   a_volt_hold: assert property (p_volt_hold) else $error("volt moved");

   property p_cd_irq;
      @(posedge mclk) disable iff (sys_rst)
      (event_r[2] || event_r[1]) && irqEnable_r[2:1] == sktsm_pkg::CARD_DETECT_IRQ_ENABLE_ON
         |=> cardStatusChangeIrq;
   endproperty
   a_cd_irq: assert property (p_cd_irq) else $error("cd irq missing");

   property p_irq_gate;
      @(posedge mclk) disable iff (sys_rst)
      !(event_r[3] && irqEnable_r[3]) && !(event_r[0] && irqEnable_r[0]) &&
      !((event_r[2] || event_r[1]) && irqEnable_r[2:1] == sktsm_pkg::CARD_DETECT_IRQ_ENABLE_ON)
         |=> !cardStatusChangeIrq;
   endproperty
   a_irq_gate: assert property (p_irq_gate) else $error("irq without enabled event");

   property p_event_clear;
      @(posedge mclk) disable iff (sys_rst)
      wrEvent |=> (event_r & $past(regWdata[3:0] & ~hwSet)) == 4'h0;
   endproperty
   a_event_clear: assert property (p_event_clear) else $error("event not cleared");

   property p_cd_event;
      @(posedge mclk) disable iff (sys_rst)
      !identifying && cardDetectTwoPin != cdTwo_r |=> event_r[2];
   endproperty
   a_cd_event: assert property (p_cd_event) else $error("cd event missing");

   property p_csts_rise_only;
      @(posedge mclk) disable iff (sys_rst)
      cardBus_r && csts_r && !cardStatusPin && !event_r[0] && !wrForce |=> !event_r[0];
   endproperty
   a_csts_rise_only: assert property (p_csts_rise_only) else $error("csts fall event");

   property p_csts_both;
      @(posedge mclk) disable iff (sys_rst)
      !cardBus_r && csts_r != cardStatusPin |=> event_r[0];
   endproperty
   a_csts_both: assert property (p_csts_both) else $error("csts edge missed");

   property p_present_upper;
      @(posedge mclk) disable iff (sys_rst)
      regRead && regAddr == sktsm_pkg::OFF_PRESENT |=> regRdata[31:28] == sktsm_pkg::SOCKV_RST;
   endproperty
   a_present_upper: assert property (p_present_upper) else $error("socket volt bits");

   property p_cd_mirror;
      @(posedge mclk) disable iff (sys_rst)
      !identifying |=> cdOne_r == $past(cardDetectOnePin) && cdTwo_r == $past(cardDetectTwoPin);
   endproperty
   a_cd_mirror: assert property (p_cd_mirror) else $error("cd not mirrored");

   property p_pwr_mirror;
      @(posedge mclk) disable iff (sys_rst)
      1'b1 |=> pwr_r == $past(socketPowered);
   endproperty
   a_pwr_mirror: assert property (p_pwr_mirror) else $error("power bit");

   property p_badreq_set;
      @(posedge mclk) disable iff (sys_rst)
      invalidSupplyReq |=> badReq_r;
   endproperty
   a_badreq_set: assert property (p_badreq_set) else $error("bad request lost");

   property p_dloss_set;
      @(posedge mclk) disable iff (sys_rst)
      dataLossSet |=> dataLoss_r;
   endproperty
   a_dloss_set: assert property (p_dloss_set) else $error("data loss lost");

   property p_notcard_hold;
      @(posedge mclk) disable iff (sys_rst)
      !insertDone && !wrForce |=> $stable(notCard_r);
   endproperty
   a_notcard_hold: assert property (p_notcard_hold) else $error("not-card moved");

   property p_ps_readonly;
      @(posedge mclk) disable iff (sys_rst)
      regWrite && regAddr == sktsm_pkg::OFF_PRESENT && !insertDone
         |=> $stable({cardVolt_r, cardBus_r, card16_r, notCard_r, irqEnable_r});
   endproperty
   a_ps_readonly: assert property (p_ps_readonly) else $error("present written");

   property p_force_fields;
      @(posedge mclk) disable iff (sys_rst)
      wrForce |=> cardVolt_r == $past(regWdata[sktsm_pkg::POS_CARD_HI:sktsm_pkg::POS_CARD_LO])
         && notCard_r == $past(regWdata[sktsm_pkg::POS_NOCARD]);
   endproperty
   a_force_fields: assert property (p_force_fields) else $error("force not shown");

   property p_insert_latch;
      @(posedge mclk) disable iff (sys_rst)
      insertDone && !wrForce |=> cardVolt_r == $past(insertCardVolt);
   endproperty
   a_insert_latch: assert property (p_insert_latch) else $error("card volt not latched");

   property p_mask_write;
      @(posedge mclk) disable iff (sys_rst)
      wrMask |=> irqEnable_r == $past(regWdata[3:0]);
   endproperty
   a_mask_write: assert property (p_mask_write) else $error("mask write");
endmodule // sktsm_socket_regs

// *** sim/sktsm_card_model.sv ***
`timescale 1ns/1ps
// card seated in the socket, seen from the socket pins
module sktsm_card_model (
   // bench control
   input  wire logic inserted,
   input  wire logic statusLvl,
   // socket pins
   output logic      cardDetectOnePin,
   output logic      cardDetectTwoPin,
   output logic      cardStatusPin,
   output logic      cardIntPin
);
   // empty socket: pull-ups on detect lines, pull-downs on status lines
   assign cardDetectOnePin = ~inserted;
   assign cardDetectTwoPin = ~inserted;
   assign cardStatusPin    = inserted & statusLvl;
   assign cardIntPin       = inserted;
endmodule // sktsm_card_model

// *** sim/test_socket_status_mask_and_state.sv ***
`timescale 1ns/1ps
module test_socket_status_mask_and_state;
   localparam logic [7:0]  EV  = sktsm_pkg::OFF_EVENT;
   localparam logic [7:0]  MK  = sktsm_pkg::OFF_MASK;
   localparam logic [7:0]  PS  = sktsm_pkg::OFF_PRESENT;
   localparam logic [7:0]  FC  = sktsm_pkg::OFF_FORCE;
   localparam logic [31:0] ALL = 32'hFFFF_FFFF;
   logic        mclk = 1'b0;
   logic        sys_rst = 1'b1;
   logic [7:0]  regAddr = 8'h00;
   logic        regWrite = 1'b0;
   logic        regRead = 1'b0;
   logic [31:0] regWdata = 32'h0;
   logic [31:0] regRdata;
   logic [3:0]  strb = 4'h0;
   logic [3:0]  insertCardVolt = 4'h0;
   logic        insertValid = 1'b1;
   logic        insertCardBus = 1'b0;
   logic        socketPowered = 1'b0;
   logic        identifying = 1'b0;
   logic        inserted = 1'b0;
   logic        statusLvl = 1'b0;
   logic        cd1, cd2, csts, cint, irq, reint;
   int          err_total = 0;
   int          cmp_count = 0;

   always #5 mclk = ~mclk;

   sktsm_socket_regs DUT (
      .mclk, .sys_rst, .regAddr, .regWrite, .regRead, .regWdata, .regRdata,
      .cardDetectOnePin(cd1), .cardDetectTwoPin(cd2), .cardStatusPin(csts),
      .cardIntPin(cint), .socketPowered, .identifying, .insertDone(strb[0]),
      .insertValid, .insertCardVolt, .insertCardBus, .insert16Bit(~insertCardBus),
      .invalidSupplyReq(strb[1]), .dataLossSet(strb[2]), .dataLossClear(strb[3]),
      .cardStatusChangeIrq(irq), .reinterrogateReq(reint)
   );
   sktsm_card_model card (.inserted, .statusLvl, .cardDetectOnePin(cd1),
      .cardDetectTwoPin(cd2), .cardStatusPin(csts), .cardIntPin(cint));

   //////////////////////////////////////////////////////////////////////////
   task automatic end_sim;
      $display("compares %0d mismatches %0d", cmp_count, err_total);
      if (err_total == 0 && cmp_count > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         err_total++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge mclk);
      regAddr  <= a;
      regWdata <= d;
      regWrite <= 1'b1;
      @(posedge mclk);
      regWrite <= 1'b0;
   endtask
   task automatic rdchk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
      @(posedge mclk);
      regAddr <= a;
      regRead <= 1'b1;
      @(posedge mclk);
      regRead <= 1'b0;
      #1 chk(regRdata & m, e);
   endtask
   task automatic pulse(input logic [3:0] m);
      @(posedge mclk);
      strb <= m;
      @(posedge mclk);
      strb <= 4'h0;
   endtask
   // bounded wait; a timeout is a mismatch and ends the run
   task automatic wirq(input logic e);
      #1;
      for (int i = 0; i < 8 && irq !== e; i++) begin
         @(posedge mclk);
         #1;
      end
      chk({31'h0, irq}, {31'h0, e});
      if (irq !== e) end_sim();
   endtask

   //////////////////////////////////////////////////////////////////////////
   task automatic t_reset;
      rdchk(MK, ALL, 32'h0);
      rdchk(PS, ALL, 32'h3000_0006);
      wr(MK, ALL);
      rdchk(MK, ALL, 32'h0000_000F);
      wr(MK, 32'h0);
      wr(PS, ALL);
      rdchk(PS, ALL, 32'h3000_0006);
      $display("test reset done");
   endtask
   task automatic t_detect;
      @(posedge mclk);
      inserted <= 1'b1;
      repeat (3) @(posedge mclk);
      rdchk(EV, ALL, 32'h0000_0006);
      chk({31'h0, irq}, 32'h0);
      rdchk(PS, 32'h0000_0046, 32'h0000_0040);
      wr(MK, {29'h0, sktsm_pkg::CARD_DETECT_IRQ_ENABLE_ON, 1'b0});
      wirq(1'b1);
      wr(EV, 32'h0000_0006);
      rdchk(EV, ALL, 32'h0);
      wirq(1'b0);
      @(posedge mclk);
      identifying <= 1'b1;
      inserted    <= 1'b0;
      repeat (3) @(posedge mclk);
      rdchk(PS, 32'h0000_0006, 32'h0);
      @(posedge mclk);
      identifying <= 1'b0;
      repeat (3) @(posedge mclk);
      rdchk(PS, 32'h0000_0006, 32'h0000_0006);
      @(posedge mclk);
      inserted <= 1'b1;
      repeat (3) @(posedge mclk);
      wr(MK, 32'h0000_0001);
      wr(EV, ALL);
      @(posedge mclk);
      statusLvl <= 1'b1;
      wirq(1'b1);
      wr(EV, ALL);
      wirq(1'b0);
      @(posedge mclk);
      statusLvl <= 1'b0;
      wirq(1'b1);
      wr(EV, ALL);
      $display("test detect done");
   endtask
   task automatic t_insert;
      @(posedge mclk);
      insertCardVolt <= 4'hA;
      insertCardBus  <= 1'b1;
      pulse(4'h1);
      insertCardVolt <= 4'h5;
      rdchk(PS, 32'h0000_3CB0, 32'h0000_2820);
      @(posedge mclk);
      statusLvl <= 1'b1;
      repeat (3) @(posedge mclk);
      rdchk(EV, 32'h0000_0001, 32'h0000_0001);
      wr(EV, ALL);
      @(posedge mclk);
      statusLvl <= 1'b0;
      repeat (3) @(posedge mclk);
      rdchk(EV, 32'h0000_0001, 32'h0);
      @(posedge mclk);
      insertValid <= 1'b0;
      pulse(4'h1);
      rdchk(PS, 32'h0000_0080, 32'h0000_0080);
      @(posedge mclk);
      insertValid <= 1'b1;
      pulse(4'h1);
      rdchk(PS, 32'h0000_0080, 32'h0);
      $display("test insert done");
   endtask
   task automatic t_misc;
      pulse(4'h2);
      rdchk(PS, 32'h0000_0200, 32'h0000_0200);
      pulse(4'h4);
      rdchk(PS, 32'h0000_0100, 32'h0000_0100);
      pulse(4'h8);
      rdchk(PS, 32'h0000_0100, 32'h0);
      wr(MK, 32'h0000_0008);
      wr(EV, ALL);
      socketPowered <= 1'b1;
      wirq(1'b1);
      rdchk(PS, 32'h0000_0008, 32'h0000_0008);
      wr(MK, 32'h0);
      wr(EV, ALL);
      wr(FC, 32'h0000_088F);
      rdchk(EV, ALL, 32'h0000_000F);
      chk({31'h0, irq}, 32'h0);
      rdchk(PS, 32'hF000_3C80, 32'h3000_0880);
      wr(FC, 32'h0000_4000);
      #1 chk({31'h0, reint}, 32'h1);
      @(posedge mclk);
      #1 chk({31'h0, reint}, 32'h0);
      $display("test misc done");
   endtask

   initial begin
      repeat (10) @(posedge mclk);
      sys_rst <= 1'b0;
      t_reset();
      t_detect();
      t_insert();
      t_misc();
      end_sim();
   end
endmodule // test_socket_status_mask_and_state
